/* File: otdi_limit_sw.sv */
// normally closed limit switches at both travel ends
`timescale 1ns/1ps
module otdi_limit_sw (
  // end stop reached, cut cable
  input wire logic fwd_hit,
  input wire logic rev_hit,
  input wire logic broken,
  // contacts, high = closed
  output logic forward_limit_input,
  output logic reverse_limit_input
);
  // a cut cable reads as open, so it trips like an end stop
  assign forward_limit_input = !(fwd_hit || broken);
  assign reverse_limit_input = !(rev_hit || broken);
endmodule

/* File: otdi_monitor.sv */
// port assertions for the overtravel inhibit block
`timescale 1ns/1ps
module otdi_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // limit pins and register strobe
  input wire logic forward_limit_input,
  input wire logic reverse_limit_input,
  input wire logic reg_wr,
  // motion side and interrupt
  input wire logic fwd_allow,
  input wire logic rev_allow,
  input wire logic stop_req,
  input wire logic dyn_brake,
  input wire logic coast,
  input wire logic rev_brake,
  input wire logic zero_clamp,
  input wire logic speed_ref_zero,
  input wire logic [8:0] brake_torque_limit,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // six cycles covers the synchroniser and the allow output flop
  chk_fwd_run_ok: assert property (
    forward_limit_input[*6] |-> fwd_allow)
    else $error("forward blocked with closed switch");
  chk_rev_run_ok: assert property (
    reverse_limit_input[*6] |-> rev_allow)
    else $error("reverse blocked with closed switch");
  chk_no_stray_stop: assert property ((forward_limit_input &&
    reverse_limit_input)[*7] |-> !stop_req) else $error("stray stop");
  chk_block_stops: assert property (
    $fell(fwd_allow) |-> ##[0:1] stop_req)
    else $error("forward blocked without stop");
  chk_rb_zero_speed: assert property (rev_brake |->
    speed_ref_zero && stop_req && !dyn_brake && !coast)
    else $error("reverse brake without zero speed");
  chk_torque_clip: assert property (brake_torque_limit <= 9'h15e)
    else $error("torque limit above range");
  chk_stop_modes: assert property ((dyn_brake || coast || rev_brake ||
    zero_clamp) |-> stop_req) else $error("stop action without stop");
  chk_irq_drop: assert property ($fell(irq) |-> $past(reg_wr))
    else $error("interrupt dropped without write");
  cover property (rev_brake ##1 zero_clamp);
  cover property (dyn_brake ##1 coast);
  cover property ($fell(irq));
endmodule
bind otdi_top otdi_monitor u_otdi_monitor (.clk_sys, .rst_n,
  .forward_limit_input, .reverse_limit_input, .reg_wr, .fwd_allow,
  .rev_allow, .stop_req, .dyn_brake, .coast, .rev_brake, .zero_clamp,
  .speed_ref_zero, .brake_torque_limit, .irq);

/* File: otdi_pkg.sv */
// types shared by the overtravel inhibit block
package otdi_pkg;
  typedef enum logic [1:0] {
    OTDI_STOP_DB_COAST,
    OTDI_STOP_INERT_COAST,
    OTDI_STOP_RB_CLAMP,
    OTDI_STOP_RB_COAST
  } otdi_stop_t;
  typedef enum logic [1:0] {
    OTDI_RUN,
    OTDI_BRAKING,
    OTDI_HOLD
  } otdi_state_t;
endpackage

/* File: otdi_regs.svh */
// register offsets, field positions and reset values for overtravel
`ifndef OTDI_REGS_SVH
`define OTDI_REGS_SVH
`define OTDI_ADDR_W 4
`define OTDI_OFS_CFG 4'h0
`define OTDI_OFS_TORQ 4'h1
`define OTDI_OFS_STAT 4'h2
`define OTDI_OFS_IRQ_STAT 4'h3
`define OTDI_OFS_IRQ_EN 4'h4
`define OTDI_OFS_IRQ_CLR 4'h5
`define OTDI_OFS_ACTIVE 4'h6
`define OTDI_CFG_FWD_USE 0
`define OTDI_CFG_REV_USE 1
`define OTDI_CFG_STOP_LO 2
`define OTDI_CFG_ALLOC_LO 4
`define OTDI_CFG_RST 8'h00
`define OTDI_TORQ_RST 9'h12c
`define OTDI_TORQ_MAX 9'h15e
`define OTDI_ALLOC_NONE 2'h0
`define OTDI_ALLOC_FWD 2'h1
`define OTDI_ALLOC_REV 2'h2
`define OTDI_ALLOC_BOTH 2'h3
`endif

/* File: otdi_sync.sv */
// two flip-flop synchroniser for the limit switch pins
`timescale 1ns/1ps
module otdi_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // pins in, synchronised out
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);
  logic [WIDTH-1:0] meta_r;
  // refuse a zero-width instance, which has nothing to synchronise
  if (WIDTH < 1) begin : g_width_chk
    $error("otdi_sync needs at least one pin");
  end
  // reset to asserted so no false overtravel is raised at start
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '1;
      pin_sync <= '1;
    end else begin
      meta_r <= pin_in;
      pin_sync <= meta_r;
    end
  end
endmodule

/* File: otdi_tb.sv */
// self-checking bench for the overtravel inhibit block
`timescale 1ns/1ps
`include "otdi_regs.svh"
module testbench;
  logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, motor_stopped = 0;
  logic fwd_hit = 0, rev_hit = 0, broken = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  wire forward_limit_input, reverse_limit_input;
  logic fwd_allow, rev_allow, stop_req, dyn_brake, coast, rev_brake;
  logic zero_clamp, speed_ref_zero, irq;
  logic [8:0] brake_torque_limit;
  int n_mismatch = 0, samples_checked = 0;
  // all single-bit outputs in one word for compact compares
  wire [8:0] outs = {fwd_allow, rev_allow, stop_req, dyn_brake, coast,
    rev_brake, zero_clamp, speed_ref_zero, irq};
  otdi_limit_sw u_otdi_limit_sw (.fwd_hit, .rev_hit, .broken,
    .forward_limit_input, .reverse_limit_input);
  otdi_top u_otdi_top (.clk_sys, .rst_n, .forward_limit_input,
    .reverse_limit_input, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .motor_stopped, .fwd_allow, .rev_allow, .stop_req,
    .dyn_brake, .coast, .rev_brake, .zero_clamp, .speed_ref_zero,
    .brake_torque_limit, .irq);
  initial forever #2 clk_sys = ~clk_sys;
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // single-cycle strobes, read data taken in the cycle after
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(string what, logic [3:0] a, logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(what, reg_rdata, exp);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd("cfg", `OTDI_OFS_CFG, 32'h0);
    rd("torq", `OTDI_OFS_TORQ, 32'h12c);
    rd("unmapped", 4'h9, 32'h0);
    broken <= 1'b1;
    tick(8);
    chk("unallocated", 32'(outs), 32'h180);
    broken <= 1'b0;
    wr(`OTDI_OFS_IRQ_EN, 32'h3);
    // every stop method, braking then holding
    for (int m = 0; m < 4; m++) begin
      wr(`OTDI_OFS_CFG, 32'h30 | 32'(m << 2));
      wr(`OTDI_OFS_ACTIVE, 32'h1);
      fwd_hit <= 1'b1;
      tick(8);
      chk("brake", 32'(outs), {23'h0, 3'b011, m == 0, m == 1, m >= 2,
        1'b0, m >= 2, 1'b1});
      motor_stopped <= 1'b1;
      tick(4);
      chk("hold", 32'(outs), {23'h0, 3'b011, 1'b0, m != 2, 1'b0,
        m == 2, 2'b01});
      rd("irq stat", `OTDI_OFS_IRQ_STAT, 32'h1);
      wr(`OTDI_OFS_IRQ_CLR, 32'h3);
      fwd_hit <= 1'b0;
      motor_stopped <= 1'b0;
      tick(8);
      chk("released", 32'(outs), 32'h180);
    end
    rev_hit <= 1'b1;
    tick(8);
    chk("rev trip", 32'(outs), 32'h14b);
    rd("stat", `OTDI_OFS_STAT, 32'h56);
    wr(`OTDI_OFS_CFG, 32'h3e);
    tick(4);
    chk("before restart", 32'(outs), 32'h14b);
    wr(`OTDI_OFS_ACTIVE, 32'h1);
    tick(8);
    chk("rev ignored", 32'(outs), 32'h181);
    rd("active", `OTDI_OFS_ACTIVE, 32'h3e);
    wr(`OTDI_OFS_IRQ_EN, 32'h0);
    tick(1);
    chk("masked", 32'(outs), 32'h180);
    rev_hit <= 1'b0;
    wr(`OTDI_OFS_TORQ, 32'h1ff);
    rd("torq clip", `OTDI_OFS_TORQ, 32'h15e);
    chk("torq port", 32'(brake_torque_limit), 32'h15e);
    // forward ignored, then unmapped, then honoured again
    wr(`OTDI_OFS_CFG, 32'h3d);
    wr(`OTDI_OFS_ACTIVE, 32'h1);
    fwd_hit <= 1'b1;
    tick(8);
    chk("fwd ignored", 32'(outs), 32'h180);
    wr(`OTDI_OFS_CFG, 32'h20);
    wr(`OTDI_OFS_ACTIVE, 32'h1);
    tick(8);
    chk("fwd unmapped", 32'(outs), 32'h180);
    wr(`OTDI_OFS_CFG, 32'h30);
    wr(`OTDI_OFS_ACTIVE, 32'h1);
    tick(8);
    chk("fwd honoured", 32'(outs), 32'h0e0);
    report_and_stop;
  end
endmodule

/* File: otdi_top.sv */
// overtravel limit logic: limit inputs, stop request and registers
`timescale 1ns/1ps
`include "otdi_regs.svh"
module otdi_top
  import otdi_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // limit switch pins, high = switch closed = run allowed
  input wire logic forward_limit_input,
  input wire logic reverse_limit_input,
  // register port
  input wire logic [`OTDI_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // motion control side
  input wire logic motor_stopped,
  output logic fwd_allow,
  output logic rev_allow,
  output logic stop_req,
  output logic dyn_brake,
  output logic coast,
  output logic rev_brake,
  output logic zero_clamp,
  output logic speed_ref_zero,
  output logic [8:0] brake_torque_limit,
  // interrupt
  output logic irq
);
  logic [1:0] lim_sync;
  logic [7:0] cfg_r;
  logic [7:0] act_r;
  logic [8:0] torq_r;
  logic [1:0] ist_r;
  logic [1:0] ien_r;
  logic [1:0] ot_prev_r;
  otdi_state_t st_r;
  otdi_state_t st_nxt;

  // stop-method decoding, shared by the state outputs below
  function automatic logic uses_rev_brake(otdi_stop_t m);
    return (m == OTDI_STOP_RB_CLAMP) || (m == OTDI_STOP_RB_COAST);
  endfunction

  function automatic logic clamps_after(otdi_stop_t m);
    return m == OTDI_STOP_RB_CLAMP;
  endfunction

  function automatic logic db_first(otdi_stop_t m);
    return m == OTDI_STOP_DB_COAST;
  endfunction

  function automatic logic coasts_first(otdi_stop_t m);
    return m == OTDI_STOP_INERT_COAST;
  endfunction

  // synchronise the limit pins before any logic reads them
  // the synchroniser resets to closed, so reset itself shows no trip
  otdi_sync #(.WIDTH(2)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_in({reverse_limit_input, forward_limit_input}),
    .pin_sync(lim_sync)
  );

  // settings in effect: cfg_r is latched into act_r only at restart
  wire fwd_ignore = act_r[`OTDI_CFG_FWD_USE];
  wire rev_ignore = act_r[`OTDI_CFG_REV_USE];
  wire [1:0] alloc = act_r[`OTDI_CFG_ALLOC_LO +: 2];
  wire otdi_stop_t stop_sel = otdi_stop_t'(act_r[`OTDI_CFG_STOP_LO +: 2]);
  // alloc bit 0 maps the forward input, bit 1 the reverse one
  wire fwd_mapped = alloc[0];
  wire rev_mapped = alloc[1];
  wire func_on = (alloc != `OTDI_ALLOC_NONE);

  // overtravel is a low (open switch) level; broken wire also trips
  // an ignored or unmapped input never trips, whatever the pin does
  wire fwd_ot = func_on & fwd_mapped & ~fwd_ignore & ~lim_sync[0];
  wire rev_ot = func_on & rev_mapped & ~rev_ignore & ~lim_sync[1];
  wire any_ot = fwd_ot | rev_ot;
  wire rb_sel = uses_rev_brake(stop_sel);

  // stop sequence: brake until stopped, then hold per method
  // releasing the limit returns to run; motion logic decides when to move
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      OTDI_RUN: if (any_ot) st_nxt = OTDI_BRAKING;
      OTDI_BRAKING: begin
        if (!any_ot) st_nxt = OTDI_RUN;
        else if (motor_stopped) st_nxt = OTDI_HOLD;
      end
      OTDI_HOLD: if (!any_ot) st_nxt = OTDI_RUN;
      // the fourth code is unused; fall back to run so the logic recovers
      default: st_nxt = OTDI_RUN;
    endcase
  end

  // restart latch, state, settings
  // settings writes wait for the apply strobe, so motion never sees half
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      act_r <= `OTDI_CFG_RST;
      st_r <= OTDI_RUN;
    end else begin
      if (reg_wr && reg_addr == `OTDI_OFS_ACTIVE && reg_wdata[0])
        act_r <= cfg_r;
      st_r <= st_nxt;
    end
  end

  // stop sequence decode
  wire braking = (st_r == OTDI_BRAKING);
  wire holding = (st_r == OTDI_HOLD);

  // next values of the stop outputs per selected method
  wire stop_req_nxt = braking | holding;
  wire dyn_brake_nxt = braking & db_first(stop_sel);
  wire rev_brake_nxt = braking & rb_sel;
  wire speed_ref_zero_nxt = braking & rb_sel;
  wire zero_clamp_nxt = holding & clamps_after(stop_sel);
  // inertial stop coasts from the start; all but method 2 coast after
  wire coast_nxt = (braking & coasts_first(stop_sel)) |
                   (holding & ~clamps_after(stop_sel));

  // output flops; allows come straight from the trip flags,
  // so a blocked direction drops one cycle ahead of stop_req
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stop_req <= 1'b0;
      dyn_brake <= 1'b0;
      coast <= 1'b0;
      rev_brake <= 1'b0;
      zero_clamp <= 1'b0;
      speed_ref_zero <= 1'b0;
      fwd_allow <= 1'b1;
      rev_allow <= 1'b1;
      brake_torque_limit <= `OTDI_TORQ_RST;
    end else begin
      fwd_allow <= ~fwd_ot;
      rev_allow <= ~rev_ot;
      stop_req <= stop_req_nxt;
      dyn_brake <= dyn_brake_nxt;
      rev_brake <= rev_brake_nxt;
      speed_ref_zero <= speed_ref_zero_nxt;
      zero_clamp <= zero_clamp_nxt;
      coast <= coast_nxt;
      brake_torque_limit <= torq_r;
    end
  end

  // register writes; torque clipped to its legal range
  // writes to read-only or unused indices fall through with no effect
  // the torque limit takes effect at once, unlike the cfg fields
  wire wr_cfg = reg_wr && reg_addr == `OTDI_OFS_CFG;
  wire wr_torq = reg_wr && reg_addr == `OTDI_OFS_TORQ;
  wire wr_ien = reg_wr && reg_addr == `OTDI_OFS_IRQ_EN;
  wire wr_clr = reg_wr && reg_addr == `OTDI_OFS_IRQ_CLR;
  wire [8:0] torq_in = (reg_wdata[8:0] > `OTDI_TORQ_MAX) ?
                       `OTDI_TORQ_MAX : reg_wdata[8:0];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= `OTDI_CFG_RST;
      torq_r <= `OTDI_TORQ_RST;
      ien_r <= 2'h0;
    end else begin
      if (wr_cfg) cfg_r <= reg_wdata[7:0];
      if (wr_torq) torq_r <= torq_in;
      if (wr_ien) ien_r <= reg_wdata[1:0];
    end
  end

  // sticky overtravel onset events; a new event beats a clear
  wire [1:0] ot_now = {rev_ot, fwd_ot};
  wire [1:0] ot_rise = ot_now & ~ot_prev_r;
  wire [1:0] clr_mask = wr_clr ? reg_wdata[1:0] : 2'h0;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ist_r <= 2'h0;
      ot_prev_r <= 2'h0;
    end else begin
      ot_prev_r <= ot_now;
      ist_r <= (ist_r & ~clr_mask) | ot_rise;
    end
  end
  // a level: stays up until software clears the status or masks it
  assign irq = |(ist_r & ien_r);

  // status word: stop flag, state, synchronised pins, live overtravel
  wire [31:0] stat_word = {25'h0, stop_req, st_r, lim_sync, ot_now};

  // read mux, one cycle latency; unmapped reads zero
  // reads have no side effects; clearing is its own write-only index
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    case (reg_addr)
      `OTDI_OFS_CFG: rd_mux = {24'h0, cfg_r};
      `OTDI_OFS_TORQ: rd_mux = {23'h0, torq_r};
      `OTDI_OFS_STAT: rd_mux = stat_word;
      `OTDI_OFS_IRQ_STAT: rd_mux = {30'h0, ist_r};
      `OTDI_OFS_IRQ_EN: rd_mux = {30'h0, ien_r};
      `OTDI_OFS_ACTIVE: rd_mux = {24'h0, act_r};
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) reg_rdata <= 32'h0;
    else reg_rdata <= reg_rd ? rd_mux : 32'h0;
  end
endmodule
